// ===== design/ars_result_status.sv
/*
  Auto-negotiation result, management address and monitor register.
  Assumes a plain register port and an engine on the same clock.
*/
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Field positions and codes live in the shared register header.
`include "ars_regs.svh"

module ars_result_status
  import ars_pkg::*;
#(
  // Management address after reset.
  parameter logic [4:0] ADDR_RESET = 5'h01
)
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Register port.
  input wire logic [`ARS_REG_AW-1:0] i_reg_addr,
  input wire logic [`ARS_REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [`ARS_REG_DW-1:0] o_reg_rdata,
  // Negotiation engine report.
  input wire ars_an_in_t i_an,
  // Serial address bits from the frame decoder.
  input wire ars_frame_t i_frame,
  // Address outputs.
  output logic [4:0] o_xcvr_mgmt_addr,
  output logic o_addr_match,
  output logic o_addr_done
);

  // Mode result bits, bit 15 down to bit 12.
  logic [3:0] res_reg;
  // Next value of the result bits.
  logic [3:0] res_next;
  // Writable management address.
  logic [4:0] addr_reg;
  // Current negotiation monitor code.
  ars_mon_t mon_reg;
  // Next value of the monitor code.
  ars_mon_t mon_next;
  // The register as read.
  ars_status_t status;
  // A register access that hits this register.
  logic hit;
  // Read word staged for the next cycle.
  logic [`ARS_REG_DW-1:0] rdata_next;

  // Only the printed offset is decoded.
  assign hit = (i_reg_addr == `ARS_REG_OFFSET);

  // The word is assembled from the fields.
  always_comb begin
    status.res_fast_full = res_reg[3];
    status.res_fast_half = res_reg[2];
    status.res_slow_full = res_reg[1];
    status.res_slow_half = res_reg[0];
    // Reserved bits are tied, never stored.
    status.rsvd = `ARS_RSVD_VAL;
    status.xcvr_mgmt_addr = addr_reg;
    status.negotiation_monitor = mon_reg;
  end

  // The engine's result selects exactly one mode bit.
  always_comb begin
    res_next = res_reg;
    if (i_an.done) begin
      // Speed first, then duplex, decide the bit.
      unique case ({i_an.fast, i_an.full})
        2'b11: begin
          res_next = `ARS_RES_FAST_FULL;
        end
        2'b10: begin
          res_next = `ARS_RES_FAST_HALF;
        end
        2'b01: begin
          res_next = `ARS_RES_SLOW_FULL;
        end
        2'b00: begin
          res_next = `ARS_RES_SLOW_HALF;
        end
      endcase
    end
  end

  // Result bits change only when a negotiation completes.
  // Software writes never reach them.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res_reg <= `ARS_RES_RST;
    end else begin
      res_reg <= res_next;
    end
  end

  // The monitor takes any legal code the engine shows.
  // An illegal code above the last one is not latched; the old one holds.
  always_comb begin
    mon_next = mon_reg;
    if (i_an.state <= `ARS_MON_MAX) begin
      mon_next = ars_mon_t'(i_an.state);
    end
  end

  // The monitor follows the engine in every cycle in which the engine shows a legal code.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon_reg <= ARS_MON_IDLE;
    end else begin
      mon_reg <= mon_next;
    end
  end

  // Only the address field takes write data.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_reg <= ADDR_RESET;
    end else if (i_reg_wr && hit) begin
      addr_reg <= i_reg_wdata[`ARS_ADDR_HI:`ARS_ADDR_LO];
    end
  end

  // Read data stands for one cycle; other cycles show zero.
  // An unmapped read answers zero as well.
  always_comb begin
    rdata_next = '0;
    if (i_reg_rd && hit) begin
      rdata_next = status;
    end
  end

  // The read word is registered.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= '0;
    end else begin
      o_reg_rdata <= rdata_next;
    end
  end

  // The address also leaves as a level for neighbouring logic.
  assign o_xcvr_mgmt_addr = addr_reg;

  // The link side compares incoming address bits with the field.
  ars_addr_match u_addr_match (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_addr(addr_reg),
    .i_frame(i_frame),
    .o_match(o_addr_match),
    .o_done(o_addr_done)
  );

  // Checks below share one clock and reset.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  // A completion carrying a given result.
  sequence s_done_ff;
    i_an.done && i_an.fast && i_an.full;
  endsequence
  sequence s_done_fh;
    i_an.done && i_an.fast && !i_an.full;
  endsequence
  sequence s_done_sf;
    i_an.done && !i_an.fast && i_an.full;
  endsequence
  sequence s_done_sh;
    i_an.done && !i_an.fast && !i_an.full;
  endsequence

  // A read of this register, with the word visible next cycle.
  sequence s_read_hit;
    i_reg_rd && hit;
  endsequence

  a_fast_full_res: assert property (
    s_done_ff |=> (res_reg == `ARS_RES_FAST_FULL))
    else $error("100M full result not reported in bit 15");

  a_fast_half_res: assert property (
    s_done_fh |=> (res_reg == `ARS_RES_FAST_HALF))
    else $error("100M half result not reported in bit 14");

  a_slow_full_res: assert property (
    s_done_sf |=> (res_reg == `ARS_RES_SLOW_FULL))
    else $error("10M full result not reported in bit 13");

  a_slow_half_res: assert property (
    s_done_sh ##1 s_read_hit |=>
      (o_reg_rdata[`ARS_RES_HI:`ARS_RES_LO] == `ARS_RES_SLOW_HALF))
    else $error("10M half result not read back in bit 12");

  a_monitor_follow: assert property (
    (i_an.state <= `ARS_MON_MAX) ##1 s_read_hit |=>
      (o_reg_rdata[`ARS_MON_HI:`ARS_MON_LO] == $past(i_an.state, 2)))
    else $error("monitor bits do not follow the engine state");

  a_monitor_legal: assert property (
    (i_an.state > `ARS_MON_MAX) |=> $stable(mon_reg) && (mon_reg <= `ARS_MON_MAX))
    else $error("monitor took an illegal code");

  a_reserved_zero: assert property (
    s_read_hit |=> (o_reg_rdata[`ARS_RSVD_HI:`ARS_RSVD_LO] == `ARS_RSVD_VAL))
    else $error("reserved bits read non-zero");

  a_ro_ignore_wr: assert property (
    (i_reg_wr && hit && !i_an.done) |=> $stable(res_reg))
    else $error("write changed a read-only result bit");

  a_addr_write: assert property (
    (i_reg_wr && hit) ##1 s_read_hit |=>
      (o_reg_rdata[`ARS_ADDR_HI:`ARS_ADDR_LO] ==
        $past(i_reg_wdata[`ARS_ADDR_HI:`ARS_ADDR_LO], 2)))
    else $error("address field did not take the written value");

endmodule : ars_result_status

// ===== inc/ars_regs.svh
/*
  Register constants for the auto-negotiation result and address register.
  Assumes it is included by bare name from the package and design files.
*/
// Contract
// - 100M full result sets bit 15, reset 1.
// - 100M half result sets bit 14, reset 1.
// - 10M full result sets bit 13, reset 1.
// - 10M half result sets bit 12, reset 1.
// - Address bit 4 goes first on link.
// - Monitor bits 3:0 follow state, reset 0.
// - Monitor codes 0 to 8 as listed.
`ifndef ARS_REGS_SVH
`define ARS_REGS_SVH

// Register index of the result and address register.
`define ARS_REG_OFFSET 5'h11
// Width of the management register address.
`define ARS_REG_AW 5
// Width of one management register.
`define ARS_REG_DW 16
// Field positions inside the register word.
`define ARS_RES_HI 15
`define ARS_RES_LO 12
`define ARS_RSVD_HI 11
`define ARS_RSVD_LO 9
`define ARS_ADDR_HI 8
`define ARS_ADDR_LO 4
`define ARS_MON_HI 3
`define ARS_MON_LO 0
// One-hot result codes, bit 15 down to bit 12.
`define ARS_RES_FAST_FULL 4'h8
`define ARS_RES_FAST_HALF 4'h4
`define ARS_RES_SLOW_FULL 4'h2
`define ARS_RES_SLOW_HALF 4'h1
// Reset values of the fields.
`define ARS_RES_RST 4'hf
`define ARS_RSVD_VAL 3'h0
`define ARS_MON_RST 4'h0
// Highest legal monitor code.
`define ARS_MON_MAX 4'h8
// Number of address bits carried on the management link.
`define ARS_ADDR_BITS 3'h5

`endif

// ===== inc/ars_pkg.sv
/*
  Types shared by the result/address register and its address matcher.
  Assumes ars_regs.svh is on the include path.
*/
`include "ars_regs.svh"

package ars_pkg;

  // Auto-negotiation monitor codes.
  typedef enum logic [3:0] {
    ARS_MON_IDLE = 4'h0,
    ARS_MON_ABIL_MATCH = 4'h1,
    ARS_MON_ACK_MATCH = 4'h2,
    ARS_MON_ACK_FAIL = 4'h3,
    ARS_MON_CONS_MATCH = 4'h4,
    ARS_MON_CONS_FAIL = 4'h5,
    ARS_MON_PD_READY = 4'h6,
    ARS_MON_PD_FAIL = 4'h7,
    ARS_MON_DONE_OK = 4'h8
  } ars_mon_t;

  // Report from the negotiation engine, same clock domain.
  typedef struct packed {
    logic done;
    logic fast;
    logic full;
    logic [3:0] state;
  } ars_an_in_t;

  // One serial address bit from the management frame decoder.
  typedef struct packed {
    logic start;
    logic valid;
    logic data;
  } ars_frame_t;

  // The register word as it is read.
  typedef struct packed {
    logic res_fast_full;
    logic res_fast_half;
    logic res_slow_full;
    logic res_slow_half;
    logic [2:0] rsvd;
    logic [4:0] xcvr_mgmt_addr;
    ars_mon_t negotiation_monitor;
  } ars_status_t;

endpackage : ars_pkg

// ===== design/ars_addr_match.sv
/*
  Serial address matcher: collects five address bits, first bit first.
  Assumes the frame decoder runs on the same clock and pulses start once.
*/
`timescale 1ns/1ps
// The address bit count lives in the shared register header.
`include "ars_regs.svh"

module ars_addr_match
  import ars_pkg::*;
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Own address and incoming bits.
  input wire logic [4:0] i_addr,
  input wire ars_frame_t i_frame,
  // Result of the comparison.
  output logic o_match,
  output logic o_done
);

  // Bits collected so far, newest in bit 0.
  logic [4:0] shift_reg;
  // Number of bits collected in this frame.
  logic [2:0] cnt_reg;
  // First bit seen in this frame, kept for checking only.
  logic first_bit_reg;
  // Word formed by the bit arriving now.
  logic [4:0] word_next;

  assign word_next = {shift_reg[3:0], i_frame.data};

  // The first bit lands in the top position after five shifts.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_reg <= 5'h00;
      cnt_reg <= 3'h0;
    end else if (i_frame.start) begin
      cnt_reg <= 3'h0;
    end else if (i_frame.valid && cnt_reg != `ARS_ADDR_BITS) begin
      shift_reg <= word_next;
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  // Comparison is made as the fifth bit arrives.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_match <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_frame.start) begin
        o_match <= 1'b0;
      end else if (i_frame.valid && cnt_reg == `ARS_ADDR_BITS - 3'h1) begin
        o_done <= 1'b1;
        o_match <= (word_next == i_addr);
      end
    end
  end

  // Helper that remembers the first bit of each frame.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_bit_reg <= 1'b0;
    end else if (!i_frame.start && i_frame.valid && cnt_reg == 3'h0) begin
      first_bit_reg <= i_frame.data;
    end
  end

  a_addr_msb_first: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (o_done && o_match) |-> (first_bit_reg == i_addr[4]))
    else $error("first address bit is not the address MSB");

endmodule : ars_addr_match

// ===== test/ars_mgmt_model.sv
/*
  Management-side model that shifts a five-bit address into the block.
  Assumes one shared clock; i_go is a one-cycle request from the bench.
*/
`timescale 1ns/1ps

module ars_mgmt_model
  import ars_pkg::*;
(
  // Clock and request.
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic [4:0] i_addr,
  // Serial bits toward the block.
  output ars_frame_t o_frame
);
  int cnt_reg = 0; // Bits still to send.
  logic [4:0] sh_reg = 5'h00; // Address being shifted out.

  initial o_frame = '0;

  // Sends start, then five bits high bit first; idle data toggles.
  always @(posedge i_ref_clk) begin
    o_frame.start <= i_go;
    if (i_go) begin
      o_frame.valid <= 1'b0;
      o_frame.data <= ~o_frame.data;
      cnt_reg <= 5;
      sh_reg <= i_addr;
    end else if (cnt_reg > 0) begin
      o_frame.valid <= 1'b1;
      o_frame.data <= sh_reg[4];
      sh_reg <= {sh_reg[3:0], 1'b0};
      cnt_reg <= cnt_reg - 1;
    end else begin
      o_frame.valid <= 1'b0;
      o_frame.data <= ~o_frame.data; // Stale bit must not look valid.
    end
  end
endmodule : ars_mgmt_model

// ===== test/ars_result_status_bench.sv
/*
  Self-checking bench for the result, address and monitor register.
  Assumes the package is compiled first; one 50 MHz clock.
*/
`timescale 1ns/1ps

module ars_result_status_bench
  import ars_pkg::*;
;
  // One table row: engine report and the word a read should return.
  typedef struct {
    logic fast;
    logic full;
    logic [3:0] st;
    logic [15:0] exp;
  } ars_row_t;

  logic i_ref_clk = 1'b0; // Bench clock.
  logic i_arst_n = 1'b0; // Reset, active low.
  logic [4:0] i_reg_addr = 5'h00; // Register index.
  logic [15:0] i_reg_wdata = 16'h0000; // Write data.
  logic i_reg_wr = 1'b0; // Write strobe.
  logic i_reg_rd = 1'b0; // Read strobe.
  logic [15:0] o_reg_rdata; // Read word.
  ars_an_in_t i_an = '0; // Engine report.
  ars_frame_t frame; // Serial bits from the model.
  logic go = 1'b0; // Start of a model frame.
  logic [4:0] go_addr = 5'h00; // Address the model sends.
  logic [4:0] o_xcvr_mgmt_addr; // Address field.
  logic o_addr_match; // Address comparison level.
  logic o_addr_done; // End of frame pulse.
  int fail_count = 0; // Mismatches.
  int checks_done = 0; // Comparisons.
  int cyc = 0; // Cycle counter for the timeout.
  logic [15:0] rd_val; // Last word read.
  ars_row_t rows [9] = '{
    '{1, 1, 4'h0, 16'h81f0}, '{1, 0, 4'h1, 16'h41f1},
    '{0, 1, 4'h2, 16'h21f2}, '{0, 0, 4'h3, 16'h11f3},
    '{1, 1, 4'h4, 16'h81f4}, '{1, 0, 4'h5, 16'h41f5},
    '{0, 1, 4'h6, 16'h21f6}, '{0, 0, 4'h7, 16'h11f7},
    '{1, 1, 4'h8, 16'h81f8}};

  ars_result_status dut_u (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_an(i_an), .i_frame(frame),
    .o_xcvr_mgmt_addr(o_xcvr_mgmt_addr), .o_addr_match(o_addr_match),
    .o_addr_done(o_addr_done));

  ars_mgmt_model mgmt_u (
    .i_ref_clk(i_ref_clk), .i_go(go), .i_addr(go_addr), .o_frame(frame));

  // Clock of 20 ns period.
  always #10 i_ref_clk = ~i_ref_clk;

  // Cuts a hang short.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      wrap_up();
    end
  end

  // Compares one value and reports a difference.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One write cycle.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask : wr

  // One read cycle; the word is taken in the cycle after the strobe.
  task automatic rd(input logic [4:0] a);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 rd_val = o_reg_rdata;
  endtask : rd

  // Sends an address frame and waits for its end.
  task automatic send(input logic [4:0] a, input logic exp_match);
    int n;
    @(posedge i_ref_clk);
    go <= 1'b1;
    go_addr <= a;
    @(posedge i_ref_clk);
    go <= 1'b0;
    #1;
    // The pulse is looked at after the edge that launches it has settled.
    for (n = 0; n < 20 && o_addr_done !== 1'b1; n++) begin
      @(posedge i_ref_clk);
      #1;
    end
    chk({15'h0, o_addr_done}, 16'h0001);
    #1 chk({15'h0, o_addr_match}, {15'h0, exp_match});
  endtask : send

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    // Reset values, then the word stands one cycle only.
    rd(5'h11);
    chk(rd_val, 16'hf010);
    @(posedge i_ref_clk);
    #1 chk(o_reg_rdata, 16'h0000);
    chk({11'h0, o_xcvr_mgmt_addr}, 16'h0001);
    // All ones written: only the address field may take it.
    // Write and read back to back, with no idle cycle between strobes.
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= 5'h11;
    i_reg_wdata <= 16'hffff;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, 16'hf1f0);
    // Table of results and monitor codes.
    foreach (rows[i]) begin
      @(posedge i_ref_clk);
      i_an <= '{1'b1, rows[i].fast, rows[i].full, rows[i].st};
      // The read follows the completion at once; results are read
      // only after a completion.
      @(posedge i_ref_clk);
      i_an.done <= 1'b0;
      i_reg_rd <= 1'b1;
      i_reg_addr <= 5'h11;
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b0;
      #1 chk(o_reg_rdata, rows[i].exp);
    end
    // Out-of-range monitor code is not taken.
    @(posedge i_ref_clk);
    i_an.state <= 4'h9;
    rd(5'h11);
    chk(rd_val, 16'h81f8);
    // Unmapped index: write ignored, read gives zero.
    wr(5'h10, 16'h0000);
    rd(5'h10);
    chk(rd_val, 16'h0000);
    rd(5'h11);
    chk(rd_val, 16'h81f8);
    // Address frames, high bit first; two matches, two misses.
    send(5'h1f, 1'b1);
    send(5'h0f, 1'b0);
    wr(5'h11, 16'h0150);
    #1 chk({11'h0, o_xcvr_mgmt_addr}, 16'h0015);
    send(5'h15, 1'b1);
    send(5'h0a, 1'b0);
    // Second reset in mid-run restores the reset word.
    @(posedge i_ref_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    rd(5'h11);
    chk(rd_val, 16'hf010);
    wrap_up();
  end
endmodule : ars_result_status_bench
